//--- usm_pkg.sv
// Purpose: Constants and state types for the synchronous master port.
// Assumes: Registers are 8 bits wide and sit in the low byte of a word.
// Notes:   Register byte address is four times the register index.
`default_nettype none
package usm_pkg;
  // Register indices.
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_RX_CTRL     = 8'h18;
  localparam logic [7:0] IDX_TX_BUF      = 8'h19;
  localparam logic [7:0] IDX_RX_BUF      = 8'h1A;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_TX_CTRL     = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIV    = 8'h99;

  // Flag and enable bit positions.
  localparam int BIT_RX_FULL   = 5;
  localparam int BIT_TX_EMPTY  = 4;
  // Receive status and control bits.
  localparam int BIT_PORT_EN   = 7;
  localparam int BIT_RX_NINE   = 6;
  localparam int BIT_SINGLE_RX = 5;
  localparam int BIT_CONT_RX   = 4;
  localparam int BIT_OVERRUN   = 1;
  localparam int BIT_RX_NINTH  = 0;
  // Transmit status and control bits.
  localparam int BIT_CLK_SRC   = 7;
  localparam int BIT_TX_NINE   = 6;
  localparam int BIT_TX_EN     = 5;
  localparam int BIT_SYNC_SEL  = 4;
  localparam int BIT_SHIFT_MT  = 1;
  localparam int BIT_TX_NINTH  = 0;

  localparam logic [3:0] LAST_BIT_8  = 4'h7;
  localparam logic [3:0] LAST_BIT_9  = 4'h8;
  localparam logic [1:0] FIFO_DEPTH  = 2'h2;
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [8:0] RESET_WORD  = 9'h000;

  typedef enum logic [1:0] {LINK_IDLE, LINK_SEND, LINK_RECV} usm_mode_t;

  typedef struct packed {
    logic            dtSync1;
    logic            dtSync2;
    logic            ack;
    logic [7:0]      rdata;
    logic            portEn;
    logic            rxNine;
    logic            singleRx;
    logic            contRx;
    logic            overrun;
    logic            clkSrc;
    logic            txNine;
    logic            transmit_enable;
    logic            syncSel;
    logic            txNinth;
    logic            tx_irq_enable;
    logic            rxIe;
    logic [7:0]      baudDiv;
    logic [7:0]      txBuf;
    logic            txBufFull;
    logic [8:0]      txShift;
    logic            txFull;
    logic [3:0]      txCnt;
    logic [8:0]      rxShift;
    logic [3:0]      rxCnt;
    logic            ck;
    logic            dtOut;
    logic [7:0]      baud_generator;
    logic [1:0][8:0] fifo;
    logic            rdPtr;
    logic [1:0]      fifoCnt;
    usm_mode_t       mode;
  } usm_state_t;
endpackage
`default_nettype wire

//--- usm_sync_master.sv
// Purpose: Synchronous master serial port with Avalon-MM register access.
// Assumes: Slave on the link is clocked by the shift clock driven here.
// Notes:   Shift clock idles low; bits go out least significant first.
//          A reception in mid-word pauses that word; it resumes where it
//          stopped, so the far side sees one stretched word.
//
// What this block does
// - Half duplex; receiving blocks sending, while sending never blocks receiving.
// - Sync select and port enable turn the pins into clock and data.
// - Clock source bit selects master; device drives the shift clock.
// - Shifter loads from buffer whenever it is empty and sending, leaving buffer empty.
// - Buffer empty flag sets on emptying; clears on a buffer write or when transmit enable clears.
// - Read-only shifter empty status reads one while shifter is empty.
// - Shifting starts once buffer holds data; bits change on rising edge.
// - Baud generator held in reset unless some enable set; starts at once.
// - Clearing transmit enable aborts, resets transmitter, releases the data pin, and the clock pin unless receiving.
// - Receive enable during sending pauses it and releases the data pin.
// - Single receive clears itself; transmission then resumes if enabled.
// - Either receive enable starts reception; data sampled on falling edge.
// - Single captures one word, continuous keeps going and takes precedence.
// - Completed word enters receive buffer; flag clears when buffer read empty.
// - Two-entry receive FIFO; a third word when full sets overrun, discarded.
// - Overrun blocks FIFO transfers; clearing continuous receive clears it.
// - Ninth bit buffered with each byte; buffer read advances both.
// - Interrupt request only when a flag and its enable are both set.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module usm_sync_master (
  input  wire logic        clk,               // 200 MHz system clock
  input  wire logic        nrst,              // Asynchronous reset, low
  input  wire logic        ce,                // Clock enable, freezes state
  input  wire logic [9:0]  avs_address,       // Byte address
  input  wire logic        avs_read,          // Read request
  input  wire logic        avs_write,         // Write request
  input  wire logic [3:0]  avs_byteenable,    // Byte lanes
  input  wire logic [31:0] avs_writedata,     // Write data
  output logic      [31:0] avs_readdata,      // Read data
  output logic             avs_waitrequest,   // Stall request
  output logic             shiftClockOut,     // Shift clock level
  output logic             shiftClockOe,      // Shift clock driven
  input  wire logic        serialDataIn,      // Data pin level
  output logic             serialDataOut,     // Data pin drive level
  output logic             serialDataOe,      // Data pin driven
  output logic             irq                // Interrupt request
);

  // The whole port is one record: q is registered, s is its next value.
  usm_pkg::usm_state_t q;
  usm_pkg::usm_state_t s;

  logic       active;
  logic       rxOn;
  logic       txOn;
  logic       runBrg;
  logic       tick;
  logic       req;
  logic       take;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rdVal;
  logic [8:0] head;
  logic [3:0] txLast;
  logic [3:0] rxLast;
  logic [8:0] word;
  logic       wrIdx;
  logic       rxFlag;
  logic       txFlag;

  always_comb
  begin
    s       = q;
    word    = usm_pkg::RESET_WORD;
    wrIdx   = 1'b0;
    tick    = 1'b0;
    idx     = avs_address[9:2];
    wbyte   = avs_writedata[7:0];
    req     = avs_read | avs_write;
    take    = req & q.ack;
    head    = q.fifo[q.rdPtr];
    rxFlag  = (q.fifoCnt != 2'h0);
    // Flag reads set after enable; rises whenever the buffer is empty.
    txFlag  = q.transmit_enable & ~q.txBufFull;
    active  = q.portEn & q.syncSel & q.clkSrc;
    rxOn    = active & (q.contRx | q.singleRx);
    txOn    = active & q.transmit_enable & ~rxOn;
    runBrg  = active & (q.transmit_enable | rxOn);
    txLast  = q.txNine ? usm_pkg::LAST_BIT_9 : usm_pkg::LAST_BIT_8;
    rxLast  = q.rxNine ? usm_pkg::LAST_BIT_9 : usm_pkg::LAST_BIT_8;

    // Two-stage synchroniser for the data pin.
    // The pin is seen two cycles late, so divisors below two read stale bits.
    s.dtSync1 = serialDataIn;
    s.dtSync2 = q.dtSync1;

    // Read data is prepared in the stalled cycle and stands when released.
    rdVal = usm_pkg::RESET_BYTE;
    case (idx)
      usm_pkg::IDX_IRQ_FLAGS:
      begin
        rdVal[usm_pkg::BIT_RX_FULL]  = rxFlag;
        rdVal[usm_pkg::BIT_TX_EMPTY] = txFlag;
      end
      usm_pkg::IDX_RX_CTRL:
      begin
        rdVal[usm_pkg::BIT_PORT_EN]   = q.portEn;
        rdVal[usm_pkg::BIT_RX_NINE]   = q.rxNine;
        rdVal[usm_pkg::BIT_SINGLE_RX] = q.singleRx;
        rdVal[usm_pkg::BIT_CONT_RX]   = q.contRx;
        rdVal[usm_pkg::BIT_OVERRUN]   = q.overrun;
        rdVal[usm_pkg::BIT_RX_NINTH]  = head[8];
      end
      usm_pkg::IDX_TX_BUF:      rdVal = q.txBuf;
      usm_pkg::IDX_RX_BUF:      rdVal = head[7:0];
      usm_pkg::IDX_IRQ_ENABLES:
      begin
        rdVal[usm_pkg::BIT_RX_FULL]  = q.rxIe;
        rdVal[usm_pkg::BIT_TX_EMPTY] = q.tx_irq_enable;
      end
      usm_pkg::IDX_TX_CTRL:
      begin
        rdVal[usm_pkg::BIT_CLK_SRC]  = q.clkSrc;
        rdVal[usm_pkg::BIT_TX_NINE]  = q.txNine;
        rdVal[usm_pkg::BIT_TX_EN]    = q.transmit_enable;
        rdVal[usm_pkg::BIT_SYNC_SEL] = q.syncSel;
        rdVal[usm_pkg::BIT_SHIFT_MT] = ~q.txFull;
        rdVal[usm_pkg::BIT_TX_NINTH] = q.txNinth;
      end
      usm_pkg::IDX_BAUD_DIV:    rdVal = q.baudDiv;
      default:                  rdVal = usm_pkg::RESET_BYTE;
    endcase

    // Every access stalls exactly one cycle while clock enable stays high.
    // One fixed wait cycle lets the read data come straight from a flop.
    s.ack = req & ~q.ack;
    if (req & ~q.ack)
    begin
      s.rdata = avs_read ? rdVal : usm_pkg::RESET_BYTE;
    end

    // Writes land at the edge that completes the access, one after the wait; other lanes are ignored.
    if (take & avs_write & avs_byteenable[0])
    begin
      case (idx)
        usm_pkg::IDX_RX_CTRL:
        begin
          s.portEn   = wbyte[usm_pkg::BIT_PORT_EN];
          s.rxNine   = wbyte[usm_pkg::BIT_RX_NINE];
          s.singleRx = wbyte[usm_pkg::BIT_SINGLE_RX];
          s.contRx   = wbyte[usm_pkg::BIT_CONT_RX];
          // Overrun clears when continuous receive is switched off.
          if (q.contRx & ~wbyte[usm_pkg::BIT_CONT_RX])
          begin
            s.overrun = 1'b0;
          end
        end
        // A write while the buffer is full replaces the unsent byte.
        usm_pkg::IDX_TX_BUF:
        begin
          s.txBuf     = wbyte;
          s.txBufFull = 1'b1;
        end
        usm_pkg::IDX_IRQ_ENABLES:
        begin
          s.rxIe = wbyte[usm_pkg::BIT_RX_FULL];
          s.tx_irq_enable = wbyte[usm_pkg::BIT_TX_EMPTY];
        end
        usm_pkg::IDX_TX_CTRL:
        begin
          s.clkSrc  = wbyte[usm_pkg::BIT_CLK_SRC];
          s.txNine  = wbyte[usm_pkg::BIT_TX_NINE];
          s.transmit_enable    = wbyte[usm_pkg::BIT_TX_EN];
          s.syncSel = wbyte[usm_pkg::BIT_SYNC_SEL];
          s.txNinth = wbyte[usm_pkg::BIT_TX_NINTH];
        end
        usm_pkg::IDX_BAUD_DIV:  s.baudDiv = wbyte;
        default:                s.baudDiv = q.baudDiv;
      endcase
    end

    // Reading the receive buffer advances data and ninth bit together.
    // The pop shares its cycle with the copy into the read data, so a word
    // landing during the wait cycle is never skipped unread.
    if (req & ~q.ack & avs_read & (idx == usm_pkg::IDX_RX_BUF) & rxFlag)
    begin
      s.rdPtr   = ~q.rdPtr;
      s.fifoCnt = q.fifoCnt - 2'h1;
    end

    // Baud generator: held at zero so the first tick comes at once.
    // Each half period of the shift clock lasts divisor plus one cycles.
    if (!runBrg)
    begin
      s.baud_generator = usm_pkg::RESET_BYTE;
      s.ck  = 1'b0;
    end
    else if (q.baud_generator == usm_pkg::RESET_BYTE)
    begin
      s.baud_generator = q.baudDiv;
      tick  = 1'b1;
    end
    else
    begin
      s.baud_generator = q.baud_generator - 8'h01;
    end

    // Turning transmit off resets the transmitter, buffer contents kept.
    if (!(active & q.transmit_enable))
    begin
      s.txFull = 1'b0;
      s.txCnt  = 4'h0;
    end
    // Reception only pauses the transmitter; it resumes afterwards.
    // A buffer written while the shifter is empty goes out at once.
    else if (txOn & ~q.txFull & s.txBufFull)
    begin
      s.txShift   = {q.txNinth, s.txBuf};
      s.txFull    = 1'b1;
      s.txBufFull = 1'b0;
      s.txCnt     = 4'h0;
    end

    // Leaving reception drops a half-shifted word; nothing of it is kept.
    if (!rxOn)
    begin
      s.rxCnt = 4'h0;
    end

    // While reception runs it owns the clock and the transmitter waits.
    if (tick & rxOn)
    begin
      // Clock pulses run for every received bit.
      if (!q.ck)
      begin
        s.ck = 1'b1;
      end
      else
      begin
        s.ck = 1'b0;
        s.rxShift[q.rxCnt] = q.dtSync2;
        if (q.rxCnt == rxLast)
        begin
          s.rxCnt = 4'h0;
          word    = q.rxNine ? s.rxShift : {1'b0, s.rxShift[7:0]};
          if (!q.overrun)
          begin
            if (s.fifoCnt == usm_pkg::FIFO_DEPTH)
            begin
              s.overrun = 1'b1;
            end
            else
            begin
              wrIdx         = s.rdPtr ^ s.fifoCnt[0];
              s.fifo[wrIdx] = word;
              s.fifoCnt     = s.fifoCnt + 2'h1;
            end
          end
          // Continuous wins; a single word ends the single request.
          if (!q.contRx)
          begin
            s.singleRx = 1'b0;
          end
        end
        else
        begin
          s.rxCnt = q.rxCnt + 4'h1;
        end
      end
    end
    // Data changes only at the rise, so it stands still around the fall.
    else if (tick & txOn & q.txFull)
    begin
      if (!q.ck)
      begin
        s.ck    = 1'b1;
        s.dtOut = q.txShift[q.txCnt];
      end
      else
      begin
        s.ck = 1'b0;
        if (q.txCnt == txLast)
        begin
          s.txFull = 1'b0;
          s.txCnt  = 4'h0;
        end
        else
        begin
          s.txCnt = q.txCnt + 4'h1;
        end
      end
    end

    // The mode is registered, so the data pin enable follows a cycle later.
    if (rxOn)
    begin
      s.mode = usm_pkg::LINK_RECV;
    end
    else if (txOn)
    begin
      s.mode = usm_pkg::LINK_SEND;
    end
    else
    begin
      s.mode = usm_pkg::LINK_IDLE;
    end
  end

  // Clock enable low freezes every field, the bus handshake included.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
    end
    else if (ce)
    begin
      q <= s;
    end
  end

  always_comb
  begin
    avs_readdata    = {24'h000000, q.rdata};
    // A frozen port keeps the bus stalled so no access is reported done.
    avs_waitrequest = req & ~(q.ack & ce);
    shiftClockOut   = q.ck;
    // Clock pin stays an output while any enable keeps the master busy.
    shiftClockOe    = runBrg;
    serialDataOut   = q.dtOut;
    case (q.mode)
      usm_pkg::LINK_SEND: serialDataOe = 1'b1;
      usm_pkg::LINK_RECV: serialDataOe = 1'b0;
      usm_pkg::LINK_IDLE: serialDataOe = 1'b0;
      default:            serialDataOe = 1'b0;
    endcase
    irq = (rxFlag & q.rxIe) | (txFlag & q.tx_irq_enable);
  end

endmodule
`default_nettype wire

//--- usm_sync_master_sva.sv
// Purpose: Port checks for the synchronous master serial port.
// Assumes: Clock enable is held high by the bench.
// Notes:   Sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module usm_sync_master_chk (
  input wire logic        clk,             // System clock
  input wire logic        nrst,            // Reset, low
  input wire logic        avs_read,        // Read request
  input wire logic        avs_write,       // Write request
  input wire logic [31:0] avs_readdata,    // Read data
  input wire logic        avs_waitrequest, // Stall
  input wire logic        shiftClockOut,   // Shift clock level
  input wire logic        shiftClockOe,    // Shift clock driven
  input wire logic        serialDataOut,   // Data level
  input wire logic        serialDataOe     // Data driven
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  wait_one_a: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus access did not take exactly one wait cycle");
  idle_nowait_a: assert property (!avs_read && !avs_write
    |-> !avs_waitrequest) else $error("wait raised with no request");
  rsvd_zero_a: assert property (avs_read && !avs_waitrequest
    |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  clk_idle_a: assert property (!shiftClockOe |=> !shiftClockOut)
    else $error("shift clock moved while released");
  clk_oe_a: assert property ($rose(shiftClockOut) |-> $past(shiftClockOe))
    else $error("shift clock rose while not driven");
  data_rel_a: assert property (!shiftClockOe |=> !serialDataOe)
    else $error("data pin still driven after clock release");
  data_edge_a: assert property (serialDataOe && $past(serialDataOe)
    && $changed(serialDataOut) |-> $rose(shiftClockOut))
    else $error("data changed away from a clock rise");
  data_hold_a: assert property (serialDataOe && $fell(shiftClockOut)
    |-> $stable(serialDataOut)) else $error("data moved at clock fall");
endmodule
bind usm_sync_master usm_sync_master_chk u_chk (
  .clk(clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .shiftClockOut(shiftClockOut), .shiftClockOe(shiftClockOe),
  .serialDataOut(serialDataOut), .serialDataOe(serialDataOe));
`default_nettype wire

//--- usm_link_slave.sv
// Purpose: Serial slave clocked by the port's shift clock.
// Assumes: Nine bits arrive per sent word; bits sent back repeat the byte every eight.
// Notes:   Counts restart whenever the clock pin is released.
`timescale 1ns/1ps
`default_nettype none
module usm_link_slave (
  input  wire logic       sck,    // Shift clock
  input  wire logic       sckOe,  // Shift clock driven
  input  wire logic       dOut,   // Port data level
  input  wire logic       dOe,    // Port drives data
  input  wire logic [7:0] rxByte, // Byte sent to the port
  output logic            dIn,    // Slave data level
  output logic [8:0]      word,   // Last word taken
  output logic            done    // Toggles per word
);
  logic [8:0] sh = 9'h000;
  int         nIn = 0;
  int         nOut = 0;
  initial dIn = 1'b0;
  initial done = 1'b0;
  initial word = 9'h000;
  // An aborted word must not shift the framing of the next one.
  always @(negedge sckOe)
  begin
    nIn = 0;
    nOut = 0;
  end
  always @(negedge sck)
    if (sckOe && dOe)
    begin
      sh = {dOut, sh[8:1]};
      nIn++;
      if (nIn == 9)
      begin
        word = sh;
        done = ~done;
        nIn = 0;
      end
    end
  always @(posedge sck)
    if (!dOe)
    begin
      dIn = rxByte[nOut];
      nOut = (nOut + 1) % 8;
    end
    else
      dIn = ~dIn;
endmodule
`default_nettype wire

//--- usm_sync_master_bench.sv
// Purpose: Self-checking bench for the synchronous master port.
// Assumes: Shift clock period 120 ns, nearest reachable at or below 125 ns.
// Notes:   Reads and received words are checked by the watcher.
`timescale 1ns/1ps
`default_nettype none
module usm_sync_master_bench;
  localparam int LIMIT = 20000;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata, q, m;
  logic        avs_waitrequest, sck, sckOe, dOut, dOe, dIn, irq, done;
  logic        doneSeen = 1'b0;
  logic [7:0]  rxByte = 8'h00;
  logic [7:0]  a, b;
  logic [8:0]  word;
  logic [31:0] expQ[$], mskQ[$], wordQ[$];
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  wire         serialData = dOe ? dOut : dIn;

  initial forever #2.5 clk = ~clk;

  usm_sync_master u_dut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .shiftClockOut(sck),
    .shiftClockOe(sckOe), .serialDataIn(serialData),
    .serialDataOut(dOut), .serialDataOe(dOe), .irq(irq));
  usm_link_slave u_slave (.sck(sck), .sckOe(sckOe), .dOut(dOut),
    .dOe(dOe), .rxByte(rxByte), .dIn(dIn), .word(word), .done(done));

  task stop_test;
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [7:0] d, input logic [7:0] k);
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= ~w;
    if (!w)
    begin
      expQ.push_back({24'h000000, d});
      mskQ.push_back({24'hFFFFFF, k});
    end
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 8'h00);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e,
                    input logic [7:0] k);
    bus(1'b0, i, e, k);
  endtask
  task automatic waitBit(input logic [7:0] i, input int n, input logic v);
    do
      rd(i, 8'h00, 8'h00);
    while (q[n] !== v);
  endtask

  always @(posedge clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      m = mskQ.pop_front();
      check(avs_readdata & m, expQ.pop_front() & m);
    end
    if (done !== doneSeen)
    begin
      doneSeen <= done;
      check({23'h000000, word}, wordQ.pop_front());
    end
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_errors++;
      stop_test();
    end
  end

  initial
  begin
    void'($urandom(32'h86A2));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(usm_pkg::IDX_IRQ_FLAGS, 8'h00, 8'hFF);
    rd(usm_pkg::IDX_RX_CTRL, 8'h00, 8'hFF);
    rd(usm_pkg::IDX_TX_BUF, 8'h00, 8'hFF);
    rd(usm_pkg::IDX_RX_BUF, 8'h00, 8'hFF);
    rd(usm_pkg::IDX_IRQ_ENABLES, 8'h00, 8'hFF);
    rd(usm_pkg::IDX_TX_CTRL, 8'h02, 8'hFF);
    rd(usm_pkg::IDX_BAUD_DIV, 8'h00, 8'hFF);
    rd(8'hFF, 8'h00, 8'hFF);
    a = 8'($urandom);
    wr(usm_pkg::IDX_BAUD_DIV, a);
    rd(usm_pkg::IDX_BAUD_DIV, a, 8'hFF);
    wr(usm_pkg::IDX_BAUD_DIV, 8'h0B);
    wr(usm_pkg::IDX_RX_CTRL, 8'h80);
    wr(usm_pkg::IDX_TX_CTRL, 8'hF1);
    rd(usm_pkg::IDX_IRQ_FLAGS, 8'h10, 8'h10);
    wr(usm_pkg::IDX_IRQ_ENABLES, 8'h10);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    wr(usm_pkg::IDX_IRQ_ENABLES, 8'h00);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    a = 8'($urandom);
    b = 8'($urandom);
    wordQ.push_back({24'h000001, a});
    wordQ.push_back({24'h000000, b});
    wr(usm_pkg::IDX_TX_BUF, a);
    // The ninth bit changes before the second byte is loaded.
    wr(usm_pkg::IDX_TX_CTRL, 8'hF0);
    wr(usm_pkg::IDX_TX_BUF, b);
    rd(usm_pkg::IDX_IRQ_FLAGS, 8'h00, 8'h10);
    rd(usm_pkg::IDX_TX_CTRL, 8'hF0, 8'h02);
    waitBit(usm_pkg::IDX_TX_CTRL, 1, 1'b1);
    rd(usm_pkg::IDX_IRQ_FLAGS, 8'h10, 8'h10);
    wr(usm_pkg::IDX_TX_BUF, a);
    waitBit(usm_pkg::IDX_TX_CTRL, 1, 1'b0);
    wr(usm_pkg::IDX_TX_CTRL, 8'h90);
    repeat (2) @(negedge clk);
    check({30'h0, sckOe, dOe}, 32'h0);
    rd(usm_pkg::IDX_TX_CTRL, 8'h92, 8'hFF);
    rxByte <= 8'($urandom);
    wr(usm_pkg::IDX_RX_CTRL, 8'hA0);
    waitBit(usm_pkg::IDX_IRQ_FLAGS, 5, 1'b1);
    rd(usm_pkg::IDX_RX_CTRL, 8'h80, 8'hF2);
    rd(usm_pkg::IDX_RX_BUF, rxByte, 8'hFF);
    rd(usm_pkg::IDX_IRQ_FLAGS, 8'h00, 8'h20);
    check({31'h0, sckOe}, 32'h0);
    rxByte <= 8'($urandom);
    wr(usm_pkg::IDX_RX_CTRL, 8'hE0);
    waitBit(usm_pkg::IDX_IRQ_FLAGS, 5, 1'b1);
    rd(usm_pkg::IDX_RX_CTRL, {7'h60, rxByte[0]}, 8'hF3);
    rd(usm_pkg::IDX_RX_BUF, rxByte, 8'hFF);
    wr(usm_pkg::IDX_IRQ_ENABLES, 8'h20);
    wr(usm_pkg::IDX_RX_CTRL, 8'h90);
    waitBit(usm_pkg::IDX_RX_CTRL, 1, 1'b1);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    rd(usm_pkg::IDX_RX_BUF, rxByte, 8'hFF);
    rd(usm_pkg::IDX_RX_BUF, rxByte, 8'hFF);
    rd(usm_pkg::IDX_IRQ_FLAGS, 8'h00, 8'h20);
    wr(usm_pkg::IDX_RX_CTRL, 8'h80);
    rd(usm_pkg::IDX_RX_CTRL, 8'h80, 8'hF2);
    stop_test();
  end
endmodule
`default_nettype wire
